// File: include/legacy16_regs.svh
`ifndef LEGACY16_REGS_SVH
`define LEGACY16_REGS_SVH

// Word offsets on the register bus
`define LC_OFF_CTRL 8'h00
`define LC_OFF_STAT 8'h04
`define LC_OFF_PSW 8'h08
`define LC_OFF_PSWOP 8'h0c
`define LC_OFF_LADDR 8'h10
`define LC_OFF_CMD 8'h14
`define LC_OFF_SRC 8'h18
`define LC_OFF_DST 8'h1c
`define LC_OFF_NPC 8'h20
`define LC_OFF_EXITPC 8'h24
// Windows: native registers at 0x40..0x7c, legacy registers at 0x80..0x9c
`define LC_GPR_WIN 2'h1
`define LC_LEG_WIN 3'h4

// Control fields
`define LC_CTRL_ENTER 0
`define LC_CTRL_EXIT 1
`define LC_CTRL_PRIV_HI 3
`define LC_CTRL_PRIV_LO 2
// Status fields
`define LC_STAT_FP 2
`define LC_STAT_PRIV 3
`define LC_STAT_SPEC 4
// Status-word operation fields
`define LC_PSWOP_OP_HI 17
`define LC_PSWOP_OP_LO 16
`define LC_PSWOP_SET 18
// Operand command fields
`define LC_CMD_SRC_HI 5
`define LC_CMD_SRC_LO 0
`define LC_CMD_DST_HI 11
`define LC_CMD_DST_LO 6
`define LC_CMD_KIND_HI 13
`define LC_CMD_KIND_LO 12
`define LC_CMD_BYTE 14
`define LC_CMD_IDX_HI 31
`define LC_CMD_IDX_LO 16

// Status word layout and reset
`define LC_PSW_KEEP 5
`define LC_PSW_TRACE 4
`define LC_PSW_RESET 16'h0000
// Register mapping
`define LC_PC_LEGACY 3'h7
`define LC_PC_NATIVE 4'hf
`define LC_PROT_LO 4'h8
`define LC_PROT_HI 4'he
`define LC_SP_LEGACY 3'h6
`define LC_USER_MODE 2'h3
`define LC_STEP_BYTE 16'h0001
`define LC_STEP_WORD 16'h0002

`endif

// File: include/legacy16_pkg.sv
package legacy16_pkg;

    // Operand addressing modes, in mode-field order 0..7
    typedef enum logic [2:0] {
        am_reg, am_reg_def, am_ainc, am_ainc_def,
        am_adec, am_adec_def, am_idx, am_idx_def
    } am_t;

    typedef enum logic [1:0] {k_plain, k_jmp, k_jsr, k_float} kind_t;

    typedef enum logic [1:0] {po_none, po_rti, po_rtt, po_cc} pswop_t;

    typedef enum logic [3:0] {
        st_idle, st_bus_rd, st_src_rd, st_src_calc, st_dst_rd, st_dst_calc,
        st_jsr_rd, st_jsr_calc, st_scr_rd, st_scr_wr
    } state_t;

endpackage

// File: src/native_gpr_mem.sv
`timescale 1ns/1ps
module native_gpr_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    // Registered read; a write lands before the next read is issued
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule // native_gpr_mem

// File: src/legacy16_compat_regs_psw.sv
`timescale 1ns/1ps
`include "legacy16_regs.svh"
// How it works
// RQ1: Legacy 16-bit addresses widen to 32 bits with zero upper half.
// RQ2: Legacy registers 0..6 are low halves of native registers 0..6.
// RQ3: Legacy program counter is the low half of native register 15.
// RQ4: Native registers 8..14 stay untouched while in compatibility mode.
// RQ5: Entry ignores native register 7 and upper halves of 0..6 and 15.
// RQ6: Leaving by exception zeroes upper halves of 0..6 and stacked PC.
// RQ7: No float accumulators; float operations are refused.
// RQ8: Destination side effects never alter a fetched source, except subroutine jump.
// RQ9: Autoincrement in jumps does not change the resulting new PC.
// RQ10: Source register side effects are seen by the destination calculation.
// RQ11: Each operand specifier has a 3-bit field choosing one of eight modes.
// RQ12: Legacy R6 is only an implied stack pointer; no hardware use or checks.
// RQ13: Status word holds trace at bit 4, N Z V C below, mirroring native bits.
// RQ14: Status word changes only by interrupt/trap return or condition-code ops.
// RQ15: Returns ignore bits 15..5 of the popped status word.
// RQ16: Only the legacy user privilege level exists.
// RQ17: Native software maps I/O before legacy programs touch device registers.
// RQ18: Status word bits 15..5 read zero and cannot be written.
module legacy16_compat_regs_psw
    import legacy16_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic compat_mode_out,
    output logic [31:0] native_addr_out,
    output logic [15:0] legacy_status_word_out,
    output logic [4:0] native_psl_low_out,
    output logic [31:0] exit_pc_out,
    output logic [31:0] new_pc_out
);
    state_t state, next_state;
    logic [31:0] cmd, src_res, dst_res;
    logic [15:0] psw;
    logic [2:0] scr_idx;
    logic fp_fault, priv_fault, spec_fault;
    logic [3:0] mem_raddr, mem_waddr;
    logic mem_we;
    logic [31:0] mem_wdata, mem_rdata, rd_word;

    function automatic logic [3:0] map_reg(input logic [2:0] r);
        map_reg = (r == `LC_PC_LEGACY) ? `LC_PC_NATIVE : {1'b0, r};
    endfunction

    // Bus decode
    logic wb_req, bus_take, is_gpr, is_leg, needs_mem, wr_ok, reg_wr;
    logic [3:0] acc_idx;
    assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign bus_take = wb_req & (state == st_idle);
    assign is_gpr = (wb_adr_in[7:6] == `LC_GPR_WIN);
    assign is_leg = (wb_adr_in[7:5] == `LC_LEG_WIN);
    assign needs_mem = is_gpr | is_leg;
    assign acc_idx = is_gpr ? wb_adr_in[5:2] : map_reg(wb_adr_in[4:2]); // [RQ2] [RQ3]
    assign reg_wr = bus_take & wb_we_in & ~needs_mem;
    // Native window needs all four lanes, legacy window lanes 1:0; protected natives are frozen in compatibility mode
    assign wr_ok = is_gpr ? ((wb_sel_in == 4'hf) &&
                             !(compat_mode_out && acc_idx >= `LC_PROT_LO &&
                               acc_idx <= `LC_PROT_HI)) // [RQ4]
                          : (wb_sel_in[1:0] == 2'h3);

    // Command and control decode from the write data
    kind_t wr_kind;
    am_t wr_dst_mode;
    logic cmd_wr, start_ok, ctrl_wr, exit_ok, enter_req, psw_take;
    pswop_t wr_op;
    assign wr_kind = kind_t'(wb_dat_in[`LC_CMD_KIND_HI:`LC_CMD_KIND_LO]);
    assign wr_dst_mode = am_t'(wb_dat_in[`LC_CMD_DST_HI:`LC_CMD_DST_HI-2]);
    assign cmd_wr = reg_wr && (wb_adr_in == `LC_OFF_CMD);
    assign start_ok = cmd_wr && compat_mode_out && (wr_kind != k_float) && // [RQ7]
                      !((wr_kind != k_plain) && (wr_dst_mode == am_reg));
    assign ctrl_wr = reg_wr && (wb_adr_in == `LC_OFF_CTRL);
    assign exit_ok = ctrl_wr && wb_dat_in[`LC_CTRL_EXIT] && compat_mode_out;
    assign enter_req = ctrl_wr && wb_dat_in[`LC_CTRL_ENTER] && !compat_mode_out;
    assign psw_take = reg_wr && (wb_adr_in == `LC_OFF_PSWOP);
    assign wr_op = pswop_t'(wb_dat_in[`LC_PSWOP_OP_HI:`LC_PSWOP_OP_LO]);

    // Operand engine: one specifier evaluated per calc state
    kind_t kind;
    logic [5:0] src_spec, dst_spec, cur_spec;
    am_t cur_mode;
    logic [2:0] cur_reg;
    logic [15:0] v, step, cur_ea, wb_val;
    logic wb_en;
    assign kind = kind_t'(cmd[`LC_CMD_KIND_HI:`LC_CMD_KIND_LO]);
    assign src_spec = cmd[`LC_CMD_SRC_HI:`LC_CMD_SRC_LO];
    assign dst_spec = cmd[`LC_CMD_DST_HI:`LC_CMD_DST_LO];
    assign cur_spec = (state == st_src_calc) ? src_spec : dst_spec;
    assign cur_mode = am_t'(cur_spec[5:3]); // [RQ11]
    assign cur_reg = cur_spec[2:0];
    assign v = mem_rdata[15:0]; // [RQ5]

    always_comb begin
        // Byte step only for R0..R5 in non-deferred modes
        step = (cmd[`LC_CMD_BYTE] && cur_reg < `LC_SP_LEGACY &&
                cur_mode != am_ainc_def && cur_mode != am_adec_def) ?
               `LC_STEP_BYTE : `LC_STEP_WORD;
        cur_ea = v;
        wb_val = v;
        wb_en = 1'b0;
        case (cur_mode) // [RQ11]
            am_reg, am_reg_def: begin
                cur_ea = v;
            end
            am_ainc, am_ainc_def: begin
                cur_ea = v; // [RQ9]
                wb_val = v + step;
                wb_en = 1'b1;
            end
            am_adec, am_adec_def: begin
                cur_ea = v - step;
                wb_val = v - step;
                wb_en = 1'b1;
            end
            am_idx, am_idx_def: begin
                cur_ea = v + cmd[`LC_CMD_IDX_HI:`LC_CMD_IDX_LO];
            end
            default: begin
                cur_ea = v;
            end
        endcase
    end

    // Sequencer and memory port steering
    always_comb begin
        next_state = state;
        mem_raddr = acc_idx;
        mem_we = 1'b0;
        mem_waddr = acc_idx;
        mem_wdata = is_leg ? {16'h0000, wb_dat_in[15:0]} : wb_dat_in;
        case (state)
            st_idle: begin
                if (bus_take && needs_mem) begin
                    if (!wb_we_in) begin
                        next_state = st_bus_rd;
                    end else begin
                        mem_we = wr_ok;
                    end
                end else if (start_ok) begin
                    next_state = st_src_rd;
                end else if (exit_ok) begin
                    next_state = st_scr_rd;
                end
            end
            st_bus_rd: begin
                next_state = st_idle;
            end
            st_src_rd, st_jsr_rd: begin
                mem_raddr = map_reg(src_spec[2:0]);
                next_state = (state == st_src_rd) ? st_src_calc : st_jsr_calc;
            end
            st_src_calc, st_dst_calc: begin
                // Write-back lands before the next read: source effects reach dest
                mem_we = wb_en; // [RQ10]
                mem_waddr = map_reg(cur_reg);
                mem_wdata = {16'h0000, wb_val};
                if (state == st_src_calc) begin
                    next_state = st_dst_rd;
                end else begin
                    next_state = (kind == k_jsr) ? st_jsr_rd : st_idle;
                end
            end
            st_dst_rd: begin
                mem_raddr = map_reg(dst_spec[2:0]); // [RQ10]
                next_state = st_dst_calc;
            end
            st_jsr_calc: begin
                next_state = st_idle;
            end
            st_scr_rd: begin
                mem_raddr = map_reg(scr_idx);
                next_state = st_scr_wr;
            end
            st_scr_wr: begin
                // Native 7, 8..14 and the stack pointer role of R6 are left alone
                mem_we = 1'b1; // [RQ6] [RQ12]
                mem_waddr = map_reg(scr_idx);
                mem_wdata = {16'h0000, mem_rdata[15:0]};
                next_state = (scr_idx == `LC_PC_LEGACY) ? st_idle : st_scr_rd;
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    native_gpr_mem #(.WIDTH(32), .DEPTH(16)) u_gpr (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(mem_raddr),
        .rdata_out(mem_rdata)
    );

    // Operand command and results
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd <= '0;
            src_res <= '0;
            dst_res <= '0;
            new_pc_out <= '0;
        end else begin
            if (cmd_wr) begin
                cmd <= wb_dat_in;
            end
            if (state == st_src_calc) begin
                src_res <= {16'h0000, cur_ea};
            end
            if (state == st_dst_calc) begin
                dst_res <= {16'h0000, cur_ea};
                if (kind != k_plain) begin
                    new_pc_out <= {16'h0000, cur_ea}; // [RQ9]
                end
            end
            // Only the subroutine jump lets the dest pass change its source
            if (state == st_jsr_calc) begin
                src_res <= {16'h0000, mem_rdata[15:0]}; // [RQ8]
            end
        end
    end

    // Mode control and exception exit scrub
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            compat_mode_out <= 1'b0;
            scr_idx <= '0;
            exit_pc_out <= '0;
        end else begin
            if (enter_req &&
                wb_dat_in[`LC_CTRL_PRIV_HI:`LC_CTRL_PRIV_LO] == `LC_USER_MODE) begin
                compat_mode_out <= 1'b1; // [RQ16]
            end else if (exit_ok) begin
                compat_mode_out <= 1'b0;
            end
            if (exit_ok) begin
                scr_idx <= '0;
            end else if (state == st_scr_wr) begin
                scr_idx <= scr_idx + 3'h1;
            end
            if (state == st_scr_wr && scr_idx == `LC_PC_LEGACY) begin
                exit_pc_out <= {16'h0000, mem_rdata[15:0]}; // [RQ6]
            end
        end
    end

    // Sticky faults, write one to clear, a new fault wins
    logic fp_set, priv_set, spec_set;
    logic [31:0] clr;
    assign fp_set = cmd_wr && wr_kind == k_float; // [RQ7]
    assign priv_set = enter_req &&
        wb_dat_in[`LC_CTRL_PRIV_HI:`LC_CTRL_PRIV_LO] != `LC_USER_MODE; // [RQ16]
    assign spec_set = cmd_wr && !start_ok && wr_kind != k_float;
    assign clr = (reg_wr && wb_adr_in == `LC_OFF_STAT) ? wb_dat_in : 32'h0;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fp_fault <= 1'b0;
            priv_fault <= 1'b0;
            spec_fault <= 1'b0;
        end else begin
            fp_fault <= fp_set | (fp_fault & ~clr[`LC_STAT_FP]);
            priv_fault <= priv_set | (priv_fault & ~clr[`LC_STAT_PRIV]);
            spec_fault <= spec_set | (spec_fault & ~clr[`LC_STAT_SPEC]);
        end
    end

    // Status word: direct writes to its offset are ignored
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            psw <= `LC_PSW_RESET;
        end else if (psw_take) begin // [RQ14]
            case (wr_op)
                po_rti, po_rtt: begin
                    psw <= {11'h000, wb_dat_in[`LC_PSW_KEEP-1:0]}; // [RQ15] [RQ18]
                end
                po_cc: begin
                    if (wb_dat_in[`LC_PSWOP_SET]) begin
                        psw[3:0] <= psw[3:0] | wb_dat_in[3:0];
                    end else begin
                        psw[3:0] <= psw[3:0] & ~wb_dat_in[3:0];
                    end
                end
                default: begin
                    psw <= psw;
                end
            endcase
        end
    end
    assign legacy_status_word_out = psw; // [RQ13]
    assign native_psl_low_out = psw[`LC_PSW_KEEP-1:0]; // [RQ13]

    // Legacy address widening
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            native_addr_out <= '0;
        end else if (reg_wr && wb_adr_in == `LC_OFF_LADDR) begin
            native_addr_out <= {16'h0000, wb_dat_in[15:0]}; // [RQ1]
        end
    end

    always_comb begin
        case (wb_adr_in)
            `LC_OFF_CTRL: rd_word = {28'h0, `LC_USER_MODE, 2'h0};
            `LC_OFF_STAT: rd_word = {27'h0, spec_fault, priv_fault, fp_fault,
                                     1'b0, compat_mode_out};
            `LC_OFF_PSW: rd_word = {16'h0000, psw};
            `LC_OFF_LADDR: rd_word = native_addr_out;
            `LC_OFF_CMD: rd_word = cmd;
            `LC_OFF_SRC: rd_word = src_res;
            `LC_OFF_DST: rd_word = dst_res;
            `LC_OFF_NPC: rd_word = new_pc_out;
            `LC_OFF_EXITPC: rd_word = exit_pc_out;
            default: rd_word = 32'h0;
        endcase
    end

    // Bus answer: one cycle after take, two for window reads
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else begin
            wb_ack_out <= (bus_take && !(needs_mem && !wb_we_in)) ||
                          (state == st_bus_rd);
            if (state == st_bus_rd) begin
                wb_dat_out <= is_leg ? {16'h0000, mem_rdata[15:0]} : mem_rdata; // [RQ5]
            end else if (bus_take && !wb_we_in) begin
                wb_dat_out <= rd_word;
            end
        end
    end

    a_addr_zero_ext: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ1]
        native_addr_out[31:16] == 16'h0000) else $error("native address upper half set");
    a_legacy_low_map: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ2]
        (bus_take && is_leg && wb_adr_in[4:2] != 3'h7) |-> mem_raddr == {1'b0, wb_adr_in[4:2]})
        else $error("legacy register mapped wrongly");
    a_legacy_pc_map: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ3]
        (bus_take && is_leg && wb_adr_in[4:2] == 3'h7) |-> mem_raddr == 4'hf)
        else $error("legacy pc not on native 15");
    a_protect_regs: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ4]
        (compat_mode_out && mem_we) |-> !(mem_waddr >= 4'h8 && mem_waddr <= 4'he))
        else $error("protected native register written");
    a_scrub_upper: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ6]
        exit_ok |=> (state == st_scr_rd) ##1 (mem_we && mem_wdata[31:16] == 16'h0000)
        ##1 (mem_waddr != 4'h7)) else $error("exit scrub wrong");
    a_float_refused: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ7]
        (cmd_wr && wr_kind == k_float) |=> (fp_fault && state == st_idle))
        else $error("float op not refused");
    a_src_kept: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ8]
        (state == st_dst_calc && kind != k_jsr) |=> $stable(src_res))
        else $error("source changed by dest pass");
    a_jump_pc: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ9]
        (state == st_dst_calc && kind == k_jmp && cur_mode == am_ainc)
        |=> new_pc_out[15:0] == $past(mem_rdata[15:0])) else $error("jump pc moved");
    a_psw_only_ops: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ14]
        !$stable(psw) |-> $past(psw_take)) else $error("status word changed by other path");
    a_psw_pop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ15]
        (psw_take && (wr_op == po_rti || wr_op == po_rtt))
        |=> psw == {11'h000, $past(wb_dat_in[4:0])}) else $error("popped word not applied");
    a_psw_upper: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // [RQ18]
        legacy_status_word_out[15:5] == 11'h000) else $error("status word upper bits set");
endmodule // legacy16_compat_regs_psw

// File: bench/legacy16_compat_regs_psw_test.sv
`timescale 1ns/1ps
module legacy16_compat_regs_psw_test;
    import legacy16_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic compat;
    logic [31:0] naddr;
    logic [15:0] status;
    logic [4:0] psl;
    logic [31:0] exit_pc;
    logic [31:0] new_pc;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;

    legacy16_compat_regs_psw u_legacy16_compat_regs_psw (
        .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .compat_mode_out(compat),
        .native_addr_out(naddr), .legacy_status_word_out(status),
        .native_psl_low_out(psl), .exit_pc_out(exit_pc), .new_pc_out(new_pc)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single cycle; waits for ack under a bounded count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) check("ack", 32'h0, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(name, q, exp);
    endtask

    task automatic test_reset();
        check("status", {16'h0, status}, 32'h0);
        check("compat", {31'h0, compat}, 32'h0);
        rdchk("ctrl", 8'h00, 32'h0000000c);
        rdchk("unmapped", 8'hfc, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_map();
        wr(8'h4c, 32'hdead1234);
        rdchk("legacy r3", 8'h8c, 32'h00001234);
        wr(8'h7c, 32'ha5a50400);
        rdchk("legacy pc", 8'h9c, 32'h00000400);
        wr(8'h88, 32'hffff5678);
        rdchk("native r2", 8'h48, 32'h00005678);
        wr(8'h64, 32'h12345678);
        $display("test map done");
    endtask

    task automatic test_enter();
        logic [31:0] q;
        wr(8'h00, 32'h00000001);
        xfer(1'b0, 8'h04, 32'h0, q);
        check("priv fault", q & 32'h9, 32'h8);
        wr(8'h04, 32'h0000001c);
        wr(8'h00, 32'h0000000d);
        rdchk("stat", 8'h04, 32'h00000001);
        check("compat", {31'h0, compat}, 32'h1);
        wr(8'h64, 32'h0);
        rdchk("native r9", 8'h64, 32'h12345678);
        wr(8'h10, 32'hffffbeef);
        rdchk("laddr", 8'h10, 32'h0000beef);
        check("naddr", naddr, 32'h0000beef);
        $display("test enter done");
    endtask

    task automatic psw_op(input logic [31:0] d, input logic [15:0] exp);
        wr(8'h0c, d);
        rdchk("status rd", 8'h08, {16'h0, exp});
        check("status", {16'h0, status}, {16'h0, exp});
        check("psl", {27'h0, psl}, {27'h0, exp[4:0]});
    endtask

    task automatic test_psw();
        wr(8'h08, 32'h0000ffff);
        rdchk("status hold", 8'h08, 32'h0);
        psw_op(32'h0001ffff, 16'h001f);
        psw_op(32'h0003000f, 16'h0010);
        psw_op(32'h0002ffe5, 16'h0005);
        psw_op(32'h00070002, 16'h0007);
        $display("test psw done");
    endtask

    task automatic test_operand();
        logic [31:0] q;
        wr(8'h44, 32'h00000100);
        wr(8'h14, 32'h00000251);
        rdchk("dst ea", 8'h1c, 32'h00000102);
        rdchk("r1 inc", 8'h44, 32'h00000102);
        wr(8'h4c, 32'h00000300);
        wr(8'h14, 32'h000004c3);
        rdchk("src val", 8'h18, 32'h00000300);
        rdchk("r3 inc", 8'h4c, 32'h00000302);
        wr(8'h48, 32'h00000200);
        wr(8'h14, 32'h00001480);
        rdchk("new pc", 8'h20, 32'h00000200);
        check("new pc port", new_pc, 32'h00000200);
        wr(8'h54, 32'h00000500);
        wr(8'h14, 32'h00002545);
        rdchk("jsr src", 8'h18, 32'h00000502);
        rdchk("jsr pc", 8'h20, 32'h00000500);
        wr(8'h14, 32'h00001000);
        xfer(1'b0, 8'h04, 32'h0, q);
        check("spec fault", q & 32'h10, 32'h10);
        wr(8'h14, 32'h00003000);
        xfer(1'b0, 8'h04, 32'h0, q);
        check("fp fault", q & 32'h4, 32'h4);
        $display("test operand done");
    endtask

    task automatic test_exit();
        wr(8'h4c, 32'hffff0302);
        wr(8'h00, 32'h00000002);
        rdchk("r3 upper", 8'h4c, 32'h00000302);
        rdchk("r15 upper", 8'h7c, 32'h00000400);
        check("exit pc", exit_pc, 32'h00000400);
        check("compat", {31'h0, compat}, 32'h0);
        rdchk("native r9", 8'h64, 32'h12345678);
        $display("test exit done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        test_reset();
        test_map();
        test_enter();
        test_psw();
        test_operand();
        test_exit();
        print_verdict();
    end
endmodule // legacy16_compat_regs_psw_test
